// ---- hw/faw_ctrl.sv ----
// Host controller that sends identification and word program command
// sequences to a parallel NOR flash and polls for completion.
// Assumes one user request at a time, taken while cmd_ready is high.
`timescale 1ns/1ps
module faw_ctrl
  import faw_pkg::*;
#(
  parameter int PROG_MAX = faw_pkg::PROG_MAX_CYC
)
(
  input  wire logic                       clk_sys,
  input  wire logic                       nrst,
  input  wire logic                       cmd_valid,
  input  wire faw_pkg::faw_op_type        cmd_op,
  input  wire logic [faw_pkg::ADDR_W-1:0] cmd_addr,
  input  wire logic [faw_pkg::DATA_W-1:0] cmd_data,
  input  wire logic                       byte_mode,
  output logic                            cmd_ready,
  output logic                            rsp_valid,
  output logic [faw_pkg::DATA_W-1:0]      rsp_data,
  output logic                            rsp_fail,
  output logic                            flash_ce_n,
  output logic                            flash_we_n,
  output logic                            flash_oe_n,
  output logic                            flash_rst_n,
  output logic                            flash_byte_n,
  output logic [faw_pkg::ADDR_W-1:0]      flash_addr,
  output logic [faw_pkg::DATA_W-1:0]      flash_dq_out,
  output logic                            flash_dq_oe,
  input  wire logic [faw_pkg::DATA_W-1:0] flash_dq_in
);
  import faw_pkg::*;

  faw_main_type       st, next_st;
  faw_op_type         op, next_op;
  logic [2:0]         step, next_step;
  logic [ADDR_W-1:0]  uaddr, next_uaddr;
  logic [DATA_W-1:0]  udata, next_udata;
  logic               bmode, next_bmode;
  logic               prev_tog, next_prev_tog;
  logic               have_prev, next_have_prev;
  logic               timed_out, next_timed_out;
  logic [23:0]        tmo, next_tmo;
  logic [7:0]         rcnt, next_rcnt;
  logic               next_ready, next_rsp_valid, next_rsp_fail;
  logic [DATA_W-1:0]  next_rsp_data;
  logic               next_rst_n;
  logic               eng_start, next_eng_start;
  logic               eng_wr, next_eng_wr;
  logic [ADDR_W-1:0]  eng_addr, next_eng_addr;
  logic [DATA_W-1:0]  eng_data, next_eng_data;
  logic               eng_done;
  logic [DATA_W-1:0]  eng_rdata;
  logic [DATA_W-1:0]  mask;
  logic               item_wr;
  logic [ADDR_W-1:0]  item_word;
  logic [ADDR_W-1:0]  item_addr;
  logic [DATA_W-1:0]  item_data;
  logic               last_step;

  // ****************************************************************
  // Sequence table: bus cycle for the current op and step
  // ****************************************************************
  // Command addresses are word addresses; byte mode doubles them.
  always_comb begin
    item_wr   = 1'b1;
    item_word = uaddr;
    item_data = DAT_RESET;
    last_step = 1'b1;
    case (op)
      OP_READ: begin
        item_wr = 1'b0;
      end
      OP_ID_ENTER: begin
        last_step = (step == 3'h2);
        case (step)
          3'h0: begin
            item_word = ADR_UNLOCK1;
            item_data = DAT_UNLOCK1;
          end
          3'h1: begin
            item_word = ADR_UNLOCK2;
            item_data = DAT_UNLOCK2;
          end
          default: begin
            item_word = ADR_UNLOCK1;
            item_data = DAT_ID_ENTER;
          end
        endcase
      end
      OP_PROGRAM: begin
        last_step = 1'b0;
        case (step)
          3'h0: begin
            item_word = ADR_UNLOCK1;
            item_data = DAT_UNLOCK1;
          end
          3'h1: begin
            item_word = ADR_UNLOCK2;
            item_data = DAT_UNLOCK2;
          end
          3'h2: begin
            item_word = ADR_UNLOCK1;
            item_data = DAT_PROG;
          end
          STEP_DATA: begin
            item_data = udata & mask;
          end
          STEP_POLL: begin
            item_wr = 1'b0;
          end
          default: begin
            last_step = 1'b1;
          end
        endcase
      end
      default: begin
        item_data = DAT_RESET;
      end
    endcase
    if (bmode && step < STEP_DATA && op inside {OP_ID_ENTER, OP_PROGRAM}) begin
      item_addr = {item_word[ADDR_W-2:0], 1'b0};
    end else begin
      item_addr = item_word;
    end
  end

  assign mask = bmode ? 16'h00FF : 16'hFFFF;

  // ****************************************************************
  // Main sequencer
  // ****************************************************************
  // No new request is taken until the whole sequence and its polling
  // end, so the device never sees a broken or interleaved sequence.
  always_comb begin
    next_st        = st;
    next_op        = op;
    next_step      = step;
    next_uaddr     = uaddr;
    next_udata     = udata;
    next_bmode     = bmode;
    next_prev_tog  = prev_tog;
    next_have_prev = have_prev;
    next_timed_out = timed_out;
    next_tmo       = tmo;
    next_rcnt      = rcnt;
    next_ready     = 1'b0;
    next_rsp_valid = 1'b0;
    next_rsp_fail  = rsp_fail;
    next_rsp_data  = rsp_data;
    next_rst_n     = flash_rst_n;
    next_eng_start = 1'b0;
    next_eng_wr    = eng_wr;
    next_eng_addr  = eng_addr;
    next_eng_data  = eng_data;
    if (step == STEP_POLL && tmo != 24'h000000) begin
      next_tmo = tmo - 24'h000001;
    end
    case (st)
      M_IDLE: begin
        next_ready = 1'b1;
        if (cmd_valid && cmd_ready) begin
          next_ready     = 1'b0;
          next_op        = cmd_op;
          next_uaddr     = cmd_addr;
          next_udata     = cmd_data;
          next_bmode     = byte_mode;
          next_step      = 3'h0;
          next_have_prev = 1'b0;
          next_timed_out = 1'b0;
          next_rsp_fail  = 1'b0;
          next_tmo       = 24'(PROG_MAX);
          if (cmd_op == OP_HW_RESET) begin
            next_rst_n = 1'b0;
            next_rcnt  = 8'(T_RP_CYC - 1);
            next_st    = M_RSTLO;
          end else begin
            next_st = M_ISSUE;
          end
        end
      end
      M_ISSUE: begin
        next_eng_start = 1'b1;
        next_eng_wr    = item_wr;
        next_eng_addr  = item_addr;
        next_eng_data  = item_data;
        next_st        = M_WAIT;
      end
      M_WAIT: begin
        if (eng_done) begin
          next_st = M_ISSUE;
          if (op == OP_PROGRAM && step == STEP_POLL) begin
            next_prev_tog  = eng_rdata[TOGGLE_BIT];
            next_have_prev = 1'b1;
            next_rsp_data  = eng_rdata;
            // Toggle bit still and poll bit true: operation finished
            if (have_prev && prev_tog == eng_rdata[TOGGLE_BIT] &&
                eng_rdata[POLL_BIT] == udata[POLL_BIT]) begin
              // Bits that would need 0 to 1 show up as a mismatch
              next_rsp_fail = ((eng_rdata & mask) != (udata & mask));
              next_st       = M_RESP;
            end else if (tmo == 24'h000000) begin
              next_timed_out = 1'b1;
              next_step      = STEP_ABORT;
            end
          end else if (last_step) begin
            if (!eng_wr) begin
              next_rsp_data = eng_rdata;
            end
            next_rsp_fail = timed_out;
            next_st       = M_RESP;
          end else begin
            next_step = step + 3'h1;
          end
        end
      end
      M_RESP: begin
        next_rsp_valid = 1'b1;
        next_step      = 3'h0;
        next_ready     = 1'b1;
        next_st        = M_IDLE;
      end
      M_RSTLO: begin
        if (rcnt == 8'h00) begin
          next_rst_n = 1'b1;
          next_rcnt  = 8'(T_RH_CYC - 1);
          next_st    = M_RSTHI;
        end else begin
          next_rcnt = rcnt - 8'h01;
        end
      end
      M_RSTHI: begin
        if (rcnt == 8'h00) begin
          next_st = M_RESP;
        end else begin
          next_rcnt = rcnt - 8'h01;
        end
      end
      default: begin
        next_st = M_IDLE;
      end
    endcase
  end

  // Byte mode pin follows the mode of the request in progress
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st           <= M_IDLE;
      op           <= OP_READ;
      step         <= 3'h0;
      uaddr        <= '0;
      udata        <= '0;
      bmode        <= 1'b0;
      prev_tog     <= 1'b0;
      have_prev    <= 1'b0;
      timed_out    <= 1'b0;
      tmo          <= 24'h000000;
      rcnt         <= 8'h00;
      cmd_ready    <= 1'b0;
      rsp_valid    <= 1'b0;
      rsp_fail     <= 1'b0;
      rsp_data     <= '0;
      flash_rst_n  <= 1'b1;
      flash_byte_n <= 1'b1;
      eng_start    <= 1'b0;
      eng_wr       <= 1'b0;
      eng_addr     <= '0;
      eng_data     <= '0;
    end else begin
      st           <= next_st;
      op           <= next_op;
      step         <= next_step;
      uaddr        <= next_uaddr;
      udata        <= next_udata;
      bmode        <= next_bmode;
      prev_tog     <= next_prev_tog;
      have_prev    <= next_have_prev;
      timed_out    <= next_timed_out;
      tmo          <= next_tmo;
      rcnt         <= next_rcnt;
      cmd_ready    <= next_ready;
      rsp_valid    <= next_rsp_valid;
      rsp_fail     <= next_rsp_fail;
      rsp_data     <= next_rsp_data;
      flash_rst_n  <= next_rst_n;
      flash_byte_n <= ~next_bmode;
      eng_start    <= next_eng_start;
      eng_wr       <= next_eng_wr;
      eng_addr     <= next_eng_addr;
      eng_data     <= next_eng_data;
    end
  end

  // ****************************************************************
  // Bus cycle engine
  // ****************************************************************
  faw_cycle u_cycle (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .start   (eng_start),
    .wr      (eng_wr),
    .a       (eng_addr),
    .d       (eng_data),
    .dq_in   (flash_dq_in),
    .done    (eng_done),
    .rdata   (eng_rdata),
    .ce_n    (flash_ce_n),
    .we_n    (flash_we_n),
    .oe_n    (flash_oe_n),
    .addr    (flash_addr),
    .dq_out  (flash_dq_out),
    .dq_oe   (flash_dq_oe)
  );

endmodule

// ---- shared/faw_pkg.sv ----
// Constants and types for the flash command sequencer (host side).
// Assumes a 200 MHz system clock and a parallel NOR flash on the pins.
package faw_pkg;

  // ****************************************************************
  // Clock and bus sizes
  // ****************************************************************
  localparam int CLK_MHZ = 200;
  localparam int ADDR_W  = 26;
  localparam int DATA_W  = 16;

  // ****************************************************************
  // Pin timing, in ns or us as printed, and derived cycle counts
  // ****************************************************************
  localparam int T_AS_NS  = 10;   // Address setup before write strobe
  localparam int T_WP_NS  = 35;   // Write strobe low time
  localparam int T_DH_NS  = 5;    // Data hold after strobe rise
  localparam int T_WPH_NS = 20;   // Strobe high recovery
  localparam int T_ACC_NS = 110;  // Read access time
  localparam int T_RP_NS  = 500;  // Hardware reset pulse width
  localparam int T_RH_NS  = 50;   // Reset high before first access
  localparam int T_PROG_MAX_US = 200;  // Program time limit

  localparam int T_AS_CYC  = (T_AS_NS * CLK_MHZ + 999) / 1000;
  localparam int T_WP_CYC  = (T_WP_NS * CLK_MHZ + 999) / 1000;
  localparam int T_DH_CYC  = (T_DH_NS * CLK_MHZ + 999) / 1000;
  localparam int T_WPH_CYC = (T_WPH_NS * CLK_MHZ + 999) / 1000;
  localparam int T_ACC_CYC = (T_ACC_NS * CLK_MHZ + 999) / 1000;
  localparam int T_RP_CYC  = (T_RP_NS * CLK_MHZ + 999) / 1000;
  localparam int T_RH_CYC  = (T_RH_NS * CLK_MHZ + 999) / 1000;
  localparam int PROG_MAX_CYC = T_PROG_MAX_US * CLK_MHZ;
  localparam int SYNC_CYC  = 2;   // Input synchroniser depth

  // ****************************************************************
  // Command addresses (word units) and command data
  // ****************************************************************
  localparam logic [ADDR_W-1:0] ADR_UNLOCK1 = 26'h0000555;
  localparam logic [ADDR_W-1:0] ADR_UNLOCK2 = 26'h00002AA;
  localparam logic [DATA_W-1:0] DAT_UNLOCK1 = 16'h00AA;
  localparam logic [DATA_W-1:0] DAT_UNLOCK2 = 16'h0055;
  localparam logic [DATA_W-1:0] DAT_ID_ENTER = 16'h0090;
  localparam logic [DATA_W-1:0] DAT_RESET    = 16'h00F0;
  localparam logic [DATA_W-1:0] DAT_PROG     = 16'h00A0;

  // Status bit positions on the data bus
  localparam int POLL_BIT   = 7;
  localparam int TOGGLE_BIT = 6;

  // Identification read offsets, for the user's address arithmetic
  localparam logic [7:0] OFS_MAKER   = 8'h00;
  localparam logic [7:0] OFS_DEVID1  = 8'h01;
  localparam logic [7:0] OFS_PROTECT = 8'h02;
  localparam logic [7:0] OFS_SECURE  = 8'h03;
  localparam logic [7:0] OFS_DEVID2  = 8'h0E;
  localparam logic [7:0] OFS_DEVID3  = 8'h0F;

  // Sequence steps of the program command
  localparam logic [2:0] STEP_DATA  = 3'h3;
  localparam logic [2:0] STEP_POLL  = 3'h4;
  localparam logic [2:0] STEP_ABORT = 3'h5;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    OP_READ     = 3'b000,
    OP_ID_ENTER = 3'b001,
    OP_ID_EXIT  = 3'b010,
    OP_PROGRAM  = 3'b011,
    OP_HW_RESET = 3'b100
  } faw_op_type;

  typedef enum logic [2:0] {
    M_IDLE  = 3'b000,
    M_ISSUE = 3'b001,
    M_WAIT  = 3'b010,
    M_RESP  = 3'b011,
    M_RSTLO = 3'b100,
    M_RSTHI = 3'b101
  } faw_main_type;

  typedef enum logic [2:0] {
    E_IDLE   = 3'b000,
    E_SETUP  = 3'b001,
    E_STROBE = 3'b010,
    E_HOLD   = 3'b011,
    E_RECOV  = 3'b100
  } faw_eng_type;

endpackage

// ---- hw/faw_cycle.sv ----
// One flash bus cycle, write or read, on the strobe pins.
// Assumes the caller pulses start only while the engine is in E_IDLE.
`timescale 1ns/1ps
module faw_cycle
  import faw_pkg::*;
(
  input  wire logic                      clk_sys,
  input  wire logic                      nrst,
  input  wire logic                      start,
  input  wire logic                      wr,
  input  wire logic [faw_pkg::ADDR_W-1:0] a,
  input  wire logic [faw_pkg::DATA_W-1:0] d,
  input  wire logic [faw_pkg::DATA_W-1:0] dq_in,
  output logic                           done,
  output logic [faw_pkg::DATA_W-1:0]     rdata,
  output logic                           ce_n,
  output logic                           we_n,
  output logic                           oe_n,
  output logic [faw_pkg::ADDR_W-1:0]     addr,
  output logic [faw_pkg::DATA_W-1:0]     dq_out,
  output logic                           dq_oe
);
  import faw_pkg::*;

  faw_eng_type         st, next_st;
  logic [7:0]          cnt, next_cnt;
  logic                wr_q, next_wr_q;
  logic                next_done, next_ce_n, next_we_n, next_oe_n;
  logic                next_dq_oe;
  logic [ADDR_W-1:0]   next_addr;
  logic [DATA_W-1:0]   next_dq_out, next_rdata;
  logic [DATA_W-1:0]   sync1, sync2;

  // ****************************************************************
  // Strobe sequencer
  // ****************************************************************
  // Chip enable falls first, write enable last, so the device takes
  // the address on write enable falling and data on its rise.
  always_comb begin
    next_st     = st;
    next_cnt    = cnt;
    next_wr_q   = wr_q;
    next_done   = 1'b0;
    next_ce_n   = ce_n;
    next_we_n   = we_n;
    next_oe_n   = oe_n;
    next_dq_oe  = dq_oe;
    next_addr   = addr;
    next_dq_out = dq_out;
    next_rdata  = rdata;
    case (st)
      E_IDLE: begin
        if (start) begin
          next_addr   = a;
          next_dq_out = d;
          next_wr_q   = wr;
          next_ce_n   = 1'b0;
          next_dq_oe  = wr;
          next_cnt    = 8'(T_AS_CYC);
          next_st     = E_SETUP;
        end
      end
      E_SETUP: begin
        if (cnt == 8'h00) begin
          if (wr_q) begin
            next_we_n = 1'b0;
            next_cnt  = 8'(T_WP_CYC - 1);
          end else begin
            next_oe_n = 1'b0;
            next_cnt  = 8'(T_ACC_CYC + SYNC_CYC);
          end
          next_st = E_STROBE;
        end else begin
          next_cnt = cnt - 8'h01;
        end
      end
      E_STROBE: begin
        if (cnt == 8'h00) begin
          if (wr_q) begin
            next_we_n = 1'b1;
          end else begin
            next_rdata = sync2;
            next_oe_n  = 1'b1;
          end
          next_cnt = 8'(T_DH_CYC);
          next_st  = E_HOLD;
        end else begin
          next_cnt = cnt - 8'h01;
        end
      end
      E_HOLD: begin
        if (cnt == 8'h00) begin
          next_ce_n  = 1'b1;
          next_dq_oe = 1'b0;
          next_cnt   = 8'(T_WPH_CYC - 1);
          next_st    = E_RECOV;
        end else begin
          next_cnt = cnt - 8'h01;
        end
      end
      E_RECOV: begin
        if (cnt == 8'h00) begin
          next_done = 1'b1;
          next_st   = E_IDLE;
        end else begin
          next_cnt = cnt - 8'h01;
        end
      end
      default: begin
        next_st = E_IDLE;
      end
    endcase
  end

  // Data pins come from outside the clock domain, so two stages first
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st     <= E_IDLE;
      cnt    <= 8'h00;
      wr_q   <= 1'b0;
      done   <= 1'b0;
      ce_n   <= 1'b1;
      we_n   <= 1'b1;
      oe_n   <= 1'b1;
      dq_oe  <= 1'b0;
      addr   <= '0;
      dq_out <= '0;
      rdata  <= '0;
      sync1  <= '0;
      sync2  <= '0;
    end else begin
      st     <= next_st;
      cnt    <= next_cnt;
      wr_q   <= next_wr_q;
      done   <= next_done;
      ce_n   <= next_ce_n;
      we_n   <= next_we_n;
      oe_n   <= next_oe_n;
      dq_oe  <= next_dq_oe;
      addr   <= next_addr;
      dq_out <= next_dq_out;
      rdata  <= next_rdata;
      sync1  <= dq_in;
      sync2  <= sync1;
    end
  end

endmodule

// ---- verif/faw_flash_model.sv ----
// Behavioural flash device facing the sequencer in the bench.
// Assumes strobes from the host; stuck hangs a program until reset cmd or reset pin.
`timescale 1ns/1ps
module faw_flash_model
  import faw_pkg::*;
(
  input  wire logic                       ce_n,
  input  wire logic                       we_n,
  input  wire logic                       oe_n,
  input  wire logic                       rst_n,
  input  wire logic                       byte_n,
  input  wire logic                       stuck,
  input  wire logic [faw_pkg::ADDR_W-1:0] addr,
  input  wire logic [faw_pkg::DATA_W-1:0] din,
  output logic      [faw_pkg::DATA_W-1:0] dout
);
  // ****************************************
  // Command decode and array
  // ****************************************
  // Maker code value is arbitrary, not any real part
  localparam logic [15:0] ID_MAKER = 16'h00A5;
  logic [15:0]       mem [int];
  logic [ADDR_W-1:0] la;
  logic [15:0]       pd;
  logic [1:0]        s;
  logic              id, wa, tg, hung;
  realtime           t_end;
  initial begin
    t_end = 0; s = 2'h0; id = 0; wa = 0; tg = 0; dout = 16'h0000; hung = 0;
  end
  function automatic logic [15:0] arr(input int k);
    return mem.exists(k) ? mem[k] : 16'hFFFF;
  endfunction
  function automatic logic busy();
    return hung || $realtime < t_end;
  endfunction
  // Address on the later fall, data on the earlier rise
  always @(negedge we_n or negedge ce_n) if (!we_n && !ce_n) begin
    la = addr; wa = 1;
  end
  always @(posedge we_n or posedge ce_n) if (wa) begin
    wa = 0; cmd(la, din);
  end
  // Reset drops any program and leaves identification
  always @(negedge rst_n) begin
    t_end = 0; s = 2'h0; id = 0; hung = 0;
  end
  task automatic cmd(input logic [ADDR_W-1:0] a, input logic [15:0] d);
    logic [ADDR_W-1:0] u;
    logic [15:0]       c;
    u = byte_n ? a : a >> 1;
    c = byte_n ? d : {8'h00, d[7:0]};
    // An overrun program still takes the reset command
    if (hung && c == DAT_RESET) hung = 0;
    if (busy()) return;
    if (c == DAT_RESET) begin s = 2'h0; id = 0; end
    else case (s)
      2'h0: s = (u == ADR_UNLOCK1 && c == DAT_UNLOCK1) ? 2'h1 : 2'h0;
      2'h1: s = (u == ADR_UNLOCK2 && c == DAT_UNLOCK2) ? 2'h2 : 2'h0;
      2'h2: begin
        id = id | (u == ADR_UNLOCK1 && c == DAT_ID_ENTER);
        s = (u == ADR_UNLOCK1 && c == DAT_PROG) ? 2'h3 : 2'h0;
      end
      default: begin
        // Only clears bits; busy for a fixed span then back to reads
        mem[int'(a)] = arr(int'(a)) & (byte_n ? d : {8'hFF, d[7:0]});
        pd = c; t_end = $realtime + 400; s = 2'h0;
        hung = stuck; // A stuck part never ends this program
      end
    endcase
  endtask
  // Reads; released bus shows the inverse of the last value
  always @(posedge oe_n) dout = ~dout;
  always @(negedge oe_n) if (!ce_n) begin
    if (busy()) begin
      tg = ~tg;
      dout = {8'h00, ~pd[POLL_BIT], tg, 6'h00};
    end else if (id)
      case (addr[7:0])
        8'h00:   dout = ID_MAKER;
        8'h02:   dout = {15'h0000, addr[20]};
        8'h03:   dout = 16'h0019;
        default: dout = {8'h5A, addr[7:0]};
      endcase
    else dout = arr(int'(addr));
  end
endmodule

// ---- verif/faw_ctrl_sva.sv ----
// Checker of the sequencer's flash pins and command handshake.
// Assumes it is bound to faw_ctrl and sees only its ports.
`timescale 1ns/1ps
module faw_ctrl_sva
  import faw_pkg::*;
(
  input wire logic                       clk_sys,
  input wire logic                       nrst,
  input wire logic                       cmd_valid,
  input wire logic                       cmd_ready,
  input wire logic                       rsp_valid,
  input wire logic                       flash_ce_n,
  input wire logic                       flash_we_n,
  input wire logic                       flash_oe_n,
  input wire logic                       flash_rst_n,
  input wire logic [faw_pkg::ADDR_W-1:0] flash_addr,
  input wire logic [faw_pkg::DATA_W-1:0] flash_dq_out,
  input wire logic                       flash_dq_oe
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  sequence s_wlow; !flash_we_n[*7]; endsequence
  sequence s_take; cmd_valid && cmd_ready; endsequence
  AST_WE_FRAME: assert property (!flash_we_n |-> !flash_ce_n && flash_oe_n)
    else $error("write strobe outside chip enable");
  AST_WE_WIDTH: assert property ($fell(flash_we_n) |-> s_wlow)
    else $error("write strobe too short");
  AST_DQ_DRIVE: assert property (!flash_we_n |-> flash_dq_oe)
    else $error("data not driven under write strobe");
  AST_ADDR_HOLD: assert property (!flash_ce_n && $past(!flash_ce_n) |-> $stable(flash_addr))
    else $error("address moved in a bus cycle");
  AST_DATA_HOLD: assert property ($rose(flash_we_n) |-> $stable(flash_dq_out) && flash_dq_oe)
    else $error("data moved at strobe rise");
  AST_NO_FIGHT: assert property (!flash_oe_n |-> !flash_dq_oe && flash_we_n)
    else $error("host drives during a read");
  AST_RSP_PULSE: assert property (rsp_valid |=> !rsp_valid)
    else $error("response longer than one cycle");
  AST_TAKE: assert property (s_take |=> !cmd_ready[*2])
    else $error("ready stayed up after a take");
  AST_RSP_READY: assert property (rsp_valid |-> cmd_ready)
    else $error("response without ready");
  AST_RST_PULSE: assert property ($fell(flash_rst_n) |-> (!flash_rst_n && flash_we_n)[*8])
    else $error("flash reset pulse too short");
endmodule
bind faw_ctrl faw_ctrl_sva u_sva (.clk_sys, .nrst, .cmd_valid, .cmd_ready,
  .rsp_valid, .flash_ce_n, .flash_we_n, .flash_oe_n, .flash_rst_n,
  .flash_addr, .flash_dq_out, .flash_dq_oe);

// ---- verif/tb_faw_ctrl.sv ----
// Self-checking bench for the flash command sequencer.
// Assumes faw_flash_model on the pins and a short program time limit.
`timescale 1ns/1ps
module tb_faw_ctrl;
  import faw_pkg::*;
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin \
  error_cnt++; $display("unexpected %s exp %h got %h", n, e, g); end end
  // ****************************************
  // Harness
  // ****************************************
  logic clk_sys, nrst, cmd_valid, byte_mode, stuck;
  faw_op_type        cmd_op;
  logic [ADDR_W-1:0] cmd_addr, flash_addr;
  logic [15:0]       cmd_data, rsp_data, flash_dq_out, dout;
  logic cmd_ready, rsp_valid, rsp_fail, flash_ce_n, flash_we_n, flash_oe_n;
  logic flash_rst_n, flash_byte_n, flash_dq_oe;
  int   error_cnt = 0, checks = 0;
  // Resolved data pins seen by both sides
  wire logic [15:0] dq_w = flash_dq_oe ? flash_dq_out : dout;
  faw_ctrl #(.PROG_MAX(200)) dut (.clk_sys, .nrst, .cmd_valid, .cmd_op,
    .cmd_addr, .cmd_data, .byte_mode, .cmd_ready, .rsp_valid, .rsp_data,
    .rsp_fail, .flash_ce_n, .flash_we_n, .flash_oe_n, .flash_rst_n,
    .flash_byte_n, .flash_addr, .flash_dq_out, .flash_dq_oe,
    .flash_dq_in(dq_w));
  faw_flash_model fm (.ce_n(flash_ce_n), .we_n(flash_we_n),
    .oe_n(flash_oe_n), .rst_n(flash_rst_n), .byte_n(flash_byte_n),
    .stuck, .addr(flash_addr), .din(dq_w), .dout);
  initial begin
    clk_sys = 0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // One request, inputs moved on falling edges only
  task automatic req(input faw_op_type op, input logic [25:0] a,
                     input logic [15:0] d, input logic bm);
    int n;
    n = 0;
    @(negedge clk_sys);
    while (cmd_ready !== 1'b1 && n < 3000) begin @(negedge clk_sys); n++; end
    cmd_valid = 1; cmd_op = op; cmd_addr = a; cmd_data = d; byte_mode = bm;
    @(negedge clk_sys);
    cmd_valid = 0;
    while (rsp_valid !== 1'b1 && n < 3000) begin @(negedge clk_sys); n++; end
    `CHK("rsp_valid", 1'b1, rsp_valid)
  endtask
  task automatic rd(input logic [25:0] a, input logic [15:0] e);
    req(OP_READ, a, 16'h0000, 1'b0);
    `CHK("rsp_data", e, rsp_data)
  endtask
  task automatic t_ident;
    logic [7:0] ofs [3] = '{8'h01, 8'h0E, 8'h0F};
    req(OP_ID_ENTER, 26'h0000000, 16'h0000, 1'b0);
    rd(26'h0000000, 16'h00A5);
    foreach (ofs[i]) rd({18'h00000, ofs[i]}, {8'h5A, ofs[i]});
    rd(26'h0100002, 16'h0001);
    rd(26'h0000002, 16'h0000);
    rd(26'h0000003, 16'h0019);
    req(OP_ID_EXIT, 26'h0000123, 16'h0000, 1'b0);
    rd(26'h0000000, 16'hFFFF);
  endtask
  task automatic t_prog;
    req(OP_PROGRAM, 26'h0000040, 16'h1234, 1'b0);
    `CHK("rsp_fail", 1'b0, rsp_fail)
    rd(26'h0000040, 16'h1234);
    req(OP_PROGRAM, 26'h0000040, 16'h0F0F, 1'b0);
    `CHK("rsp_fail", 1'b1, rsp_fail)
    rd(26'h0000040, 16'h0204);
    req(OP_PROGRAM, 26'h3000011, 16'hAB3C, 1'b1);
    `CHK("rsp_fail", 1'b0, rsp_fail)
    rd(26'h3000011, 16'hFF3C);
  endtask
  task automatic t_timeout;
    stuck = 1;
    req(OP_PROGRAM, 26'h0000080, 16'h0000, 1'b0);
    `CHK("rsp_fail", 1'b1, rsp_fail)
    stuck = 0;
    rd(26'h0000080, 16'h0000);
  endtask
  task automatic t_hwreset;
    req(OP_ID_ENTER, 26'h0000000, 16'h0000, 1'b0);
    req(OP_HW_RESET, 26'h0000000, 16'h0000, 1'b0);
    rd(26'h0000000, 16'hFFFF);
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Watchdog, far beyond the few thousand cycles the run needs
  initial begin
    #300us;
    error_cnt++;
    report_and_stop();
  end
  initial begin
    nrst = 0; cmd_valid = 0; cmd_op = OP_READ; cmd_addr = '0;
    cmd_data = '0; byte_mode = 0; stuck = 0;
    repeat (16) @(negedge clk_sys);
    nrst = 1;
    t_ident();
    t_prog();
    t_timeout();
    t_hwreset();
    report_and_stop();
  end
endmodule
